// ---- bench/frame_source.sv ----
// Far-end model driving the frame levels and the frame clock.
`timescale 1ns/1ps
module frame_source (
   input wire logic rx_req_in,
   input wire logic tx_req_in,
   input wire logic stall_in,
   output logic rx_frame_out,
   output logic tx_frame_out,
   output logic frame_clk_out
);
   // Levels lag by an odd delay so they never line up with the system clock.
   always @(rx_req_in) rx_frame_out <= #7 rx_req_in;
   always @(tx_req_in) tx_frame_out <= #7 tx_req_in;
   // Both levels start idle, so the synchronisers never see an unknown after reset.
   initial rx_frame_out = 1'b0;
   initial tx_frame_out = 1'b0;
   initial frame_clk_out = 1'b0;
   // The frame clock stands still outside frames and while stalled.
   always begin
      #100;
      if ((rx_frame_out || tx_frame_out) && !stall_in) frame_clk_out = ~frame_clk_out;
      else frame_clk_out = 1'b0;
   end
endmodule

// ---- bench/scl_timing_props.sv ----
// Port assertions of the SCL timing and frame monitor block.
`timescale 1ns/1ps
module scl_timing_props
   import scl_timing_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] BE_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic MASTER_RUN_IN,
   input wire logic RX_FRAME_IN,
   input wire logic TX_FRAME_IN,
   input wire logic FRAME_CLK_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic SCL_OUT,
   input wire logic [5:0] MAX_RISE_OUT,
   input wire logic PLUS_SPEED_OUT,
   input wire logic FRAME_TIMEOUT_OUT,
   input wire logic IRQ_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   AST_SCL_IDLE: assert property (!MASTER_RUN_IN [*2] |-> SCL_OUT)
      else $error("scl not idle high");
   AST_RDATA_QUIET: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
      else $error("read data outside read slot");
   AST_UNMAPPED: assert property (RD_IN && ADDR_IN == 8'h44 |=> RDATA_OUT == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_RISE_WRITE: assert property (WR_IN && ADDR_IN == OFS_RISE_TIME && BE_IN[0] |=>
      ##1 {26'h000_0000, MAX_RISE_OUT} == ($past(WDATA_IN, 2) & 32'h0000_003f))
      else $error("rise field not written");
   AST_RISE_READ: assert property (RD_IN && ADDR_IN == OFS_RISE_TIME |=>
      RDATA_OUT == {26'h000_0000, $past(MAX_RISE_OUT)}) else $error("rise readback");
   AST_PLUS_READ: assert property (RD_IN && ADDR_IN == OFS_PLUS_SPEED |=>
      RDATA_OUT == {31'h0000_0000, $past(PLUS_SPEED_OUT)}) else $error("plus readback");
   AST_IRQ_OFF: assert property (WR_IN && ADDR_IN == OFS_FRAME_MON && BE_IN[0] &&
      WDATA_IN[7:4] == 4'h0 |=> ##1 !IRQ_OUT) else $error("irq with enables off");
   AST_TMO_OFF: assert property (WR_IN && ADDR_IN == OFS_FRAME_MON && BE_IN[0] &&
      !WDATA_IN[POS_TOEN] |=> ##1 !FRAME_TIMEOUT_OUT [*2]) else $error("timeout while off");
endmodule
bind scl_timing_top scl_timing_props props_u (.*);

// ---- bench/tb_top.sv ----
// Self-checking bench of the SCL timing and frame monitor block.
`timescale 1ns/1ps
module tb_top;
   import scl_timing_pkg::*;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic rxq = 1'b0, txq = 1'b0, stall = 1'b0, rx_frame_level, tx_frame_level, fclk, scl, plus, tmo, irq;
   logic [7:0] addr = 8'h00;
   logic [3:0] be = 4'hf, m_flag = 4'h0;
   logic [5:0] rise;
   logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h2dfc_821a, m_mon = 32'h0000_0000;
   int errors = 0, cmp_count = 0, cyc = 0, i, c, hi, lo;
   always #12.5 clk = ~clk;
   scl_timing_top dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
      .BE_IN(be), .WR_IN(wr), .RD_IN(rd), .MASTER_RUN_IN(run), .RX_FRAME_IN(rx_frame_level),
      .TX_FRAME_IN(tx_frame_level), .FRAME_CLK_IN(fclk), .RDATA_OUT(rdata), .SCL_OUT(scl),
      .MAX_RISE_OUT(rise), .PLUS_SPEED_OUT(plus), .FRAME_TIMEOUT_OUT(tmo), .IRQ_OUT(irq));
   frame_source far_u (.rx_req_in(rxq), .tx_req_in(txq), .stall_in(stall),
      .rx_frame_out(rx_frame_level), .tx_frame_out(tx_frame_level), .frame_clk_out(fclk));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      if (a == OFS_FRAME_MON && b[1:0] != 2'b00) begin
         m_mon = d & 32'h0000_00f3;
         m_flag = m_flag & d[15:12];
      end
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
      @(posedge clk);
   endtask
   task automatic mon_chk();
      rd_reg(OFS_FRAME_MON, {16'h0000, m_flag, 2'b00, rxq, txq, m_mon[7:0]});
      check(irq, |(m_flag & m_mon[7:4]));
   endtask
   task automatic frame(input logic r, input logic v);
      if (r) rxq <= v;
      else txq <= v;
      repeat (10) @(posedge clk);
      if (m_mon[0]) m_flag[r ? (v ? 3 : 2) : (v ? 1 : 0)] = 1'b1;
      mon_chk();
   endtask
   task automatic report_and_stop();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 50000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_reg(OFS_CLOCK_CONFIG, RST_CLOCK_CONFIG);
      rd_reg(OFS_RISE_TIME, {26'h000_0000, RST_RISE_TIME});
      rd_reg(8'h44, 32'h0000_0000);
      wr_reg(8'h44, rnd(), 4'hf);
      rd_reg(8'h44, 32'h0000_0000);
      c = rnd();
      wr_reg(OFS_RISE_TIME, c, 4'h3);
      rd_reg(OFS_RISE_TIME, c & 32'h0000_003f);
      check(rise, c & 32'h0000_003f);
      c = rnd();
      wr_reg(OFS_PLUS_SPEED, c, 4'hf);
      rd_reg(OFS_PLUS_SPEED, c & 32'h0000_0001);
      wr_reg(OFS_PLUS_SPEED, ~c, 4'h3);
      wr_reg(OFS_PLUS_SPEED, c, 4'hc);
      rd_reg(OFS_PLUS_SPEED, ~c & 32'h0000_0001);
      check(plus, ~c & 32'h0000_0001);
      for (i = 0; i < 3; i++) begin
         c = 1 + rnd() % 8;
         wr_reg(OFS_CLOCK_CONFIG, {i > 0, i == 2, 2'b00, 12'(c)}, 4'h3);
         rd_reg(OFS_CLOCK_CONFIG, {16'h0000, i > 0, i == 2, 2'b00, 12'(c)});
         run <= 1'b1;
         @(posedge clk);
         for (hi = 0; scl !== 1'b0 && hi < 2000; hi++) @(posedge clk) #1;
         for (lo = 0; scl === 1'b0 && lo < 2000; lo++) @(posedge clk) #1;
         for (hi = 0; scl === 1'b1 && hi < 2000; hi++) @(posedge clk) #1;
         run <= 1'b0;
         check(lo, c * (i == 0 ? 1 : i == 1 ? 2 : 16));
         check(hi, c * (i == 2 ? 9 : 1));
         repeat (3) @(posedge clk);
      end
      frame(1'b1, 1'b1);
      frame(1'b1, 1'b0);
      wr_reg(OFS_FRAME_MON, 32'h0000_00a1, 4'hf);
      for (i = 0; i < 4; i++) frame(i < 2, !i[0]);
      wr_reg(OFS_FRAME_MON, 32'h0000_40a1, 4'hf);
      mon_chk();
      wr_reg(OFS_FRAME_MON, 32'h0000_40f1, 4'hf);
      mon_chk();
      wr_reg(OFS_FRAME_MON, 32'h0000_0001, 4'hf);
      stall <= 1'b1;
      frame(1'b1, 1'b1);
      repeat (FRAME_TIMEOUT_CYCLES + 100) @(posedge clk);
      check(tmo, 1'b0);
      wr_reg(OFS_FRAME_MON, 32'h0000_0003, 4'hf);
      // The limit is counted from the cycle after the enable lands.
      repeat (FRAME_TIMEOUT_CYCLES - 10) @(posedge clk);
      check(tmo, 1'b0);
      repeat (20) @(posedge clk);
      check(tmo, 1'b1);
      wr_reg(OFS_FRAME_MON, 32'h0000_0001, 4'hf);
      @(posedge clk);
      check(tmo, 1'b0);
      // A running frame clock must keep the timeout from firing.
      stall <= 1'b0;
      wr_reg(OFS_FRAME_MON, 32'h0000_0003, 4'hf);
      repeat (FRAME_TIMEOUT_CYCLES + 100) @(posedge clk);
      check(tmo, 1'b0);
      // A reset in mid-run must bring every register back to its reset value.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      m_mon = 32'h0000_0000;
      m_flag = 4'h0;
      @(posedge clk);
      rd_reg(OFS_RISE_TIME, {26'h000_0000, RST_RISE_TIME});
      rd_reg(OFS_CLOCK_CONFIG, RST_CLOCK_CONFIG);
      mon_chk();
      check(plus, 1'b0);
      check(tmo, 1'b0);
      report_and_stop();
   end
endmodule

// ---- rtl/scl_gen.sv ----
// SCL period generator producing the master clock level from the programmed count.
`timescale 1ns/1ps
module scl_gen
   import scl_timing_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire scl_timing_pkg::scl_cfg_s cfg_in,
   output logic scl_out
);
   logic [15:0] cnt_ff, nxt_cnt;
   logic scl_ff, nxt_scl;
   logic [15:0] high_len, low_len;

   always_comb begin
      if (!cfg_in.fast) begin
         high_len = {4'h0, cfg_in.count};
         low_len = {4'h0, cfg_in.count};
      end else if (!cfg_in.duty) begin
         high_len = 16'(cfg_in.count * DUTY0_HIGH_MULT);
         low_len = 16'(cfg_in.count * DUTY0_LOW_MULT);
      end else begin
         high_len = 16'(cfg_in.count * DUTY1_HIGH_MULT);
         low_len = 16'(cfg_in.count * DUTY1_LOW_MULT);
      end
      nxt_cnt = cnt_ff;
      nxt_scl = scl_ff;
      if (!run_in || cfg_in.count == 12'h000) begin
         nxt_cnt = 16'h0000;
         nxt_scl = 1'b1;
      end else if (cnt_ff + 16'h0001 >= (scl_ff ? high_len : low_len)) begin
         nxt_cnt = 16'h0000;
         nxt_scl = ~scl_ff;
      end else begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_ff <= 16'h0000;
         scl_ff <= 1'b1;
      end else begin
         cnt_ff <= nxt_cnt;
         scl_ff <= nxt_scl;
      end
   end

   assign scl_out = scl_ff;
endmodule

// ---- rtl/scl_timing_pkg.sv ----
// Package of constants and the carrier type for the SCL timing and frame monitor block.
package scl_timing_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h1c;
   localparam logic [7:0] OFS_RISE_TIME = 8'h20;
   localparam logic [7:0] OFS_FRAME_MON = 8'h80;
   localparam logic [7:0] OFS_PLUS_SPEED = 8'h90;
   localparam logic [31:0] RST_CLOCK_CONFIG = 32'h0000_0000;
   localparam logic [5:0] RST_RISE_TIME = 6'h02;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int POS_FAST = 15;
   localparam int POS_DUTY = 14;
   localparam int POS_RFR = 15;
   localparam int POS_RFF = 14;
   localparam int POS_TFR = 13;
   localparam int POS_TFF = 12;
   localparam int POS_RXL = 9;
   localparam int POS_TXL = 8;
   localparam int POS_IE_LO = 4;
   localparam int POS_TOEN = 1;
   localparam int POS_MONEN = 0;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam logic [4:0] DUTY0_HIGH_MULT = 5'h01;
   localparam logic [4:0] DUTY0_LOW_MULT = 5'h02;
   localparam logic [4:0] DUTY1_HIGH_MULT = 5'h09;
   localparam logic [4:0] DUTY1_LOW_MULT = 5'h10;
   localparam int FRAME_TIMEOUT_US = 200;
   localparam int SYS_CLK_MHZ = 40;
   localparam int FRAME_TIMEOUT_CYCLES = FRAME_TIMEOUT_US * SYS_CLK_MHZ;
   localparam int TMO_W = 14;

   typedef struct packed {
      logic fast;
      logic duty;
      logic [11:0] count;
   } scl_cfg_s;
endpackage

// ---- rtl/scl_timing_top.sv ----
// Top of the SCL timing configuration and frame monitor block.
`timescale 1ns/1ps
module scl_timing_top
   import scl_timing_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] BE_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic MASTER_RUN_IN,
   input wire logic RX_FRAME_IN,
   input wire logic TX_FRAME_IN,
   input wire logic FRAME_CLK_IN,
   output logic [31:0] RDATA_OUT,
   output logic SCL_OUT,
   output logic [5:0] MAX_RISE_OUT,
   output logic PLUS_SPEED_OUT,
   output logic FRAME_TIMEOUT_OUT,
   output logic IRQ_OUT
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   scl_cfg_s cfg_ff, nxt_cfg;
   logic [5:0] rise_ff, nxt_rise;
   logic plus_ff, nxt_plus;
   logic [3:0] flag_ff, nxt_flag;
   logic [3:0] ie_ff, nxt_ie;
   logic toen_ff, nxt_toen;
   logic monen_ff, nxt_monen;
   logic [31:0] rdata_ff, nxt_rdata;
   logic irq_ff, nxt_irq;
   logic [2:0] rx_sync_ff, tx_sync_ff, fc_sync_ff;
   logic [TMO_W-1:0] tmo_ff, nxt_tmo;
   logic tmo_out_ff, nxt_tmo_out;
   logic [3:0] ev;
   logic lo_en, hi_en;
   logic scl_w;

   // A write lands whole when either low byte lane is enabled; upper-lane enables alone are ignored.
   assign lo_en = WR_IN && (BE_IN[1:0] != 2'b00);
   assign hi_en = WR_IN && (BE_IN[3:2] != 2'b00);

   // Pins cross into the bus clock through two flops; the third flop only feeds edge detection.
   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         rx_sync_ff <= 3'h0;
         tx_sync_ff <= 3'h0;
         fc_sync_ff <= 3'h0;
      end else begin
         rx_sync_ff <= {rx_sync_ff[1:0], RX_FRAME_IN};
         tx_sync_ff <= {tx_sync_ff[1:0], TX_FRAME_IN};
         fc_sync_ff <= {fc_sync_ff[1:0], FRAME_CLK_IN};
      end
   end

   assign ev = {rx_sync_ff[1] & ~rx_sync_ff[2], ~rx_sync_ff[1] & rx_sync_ff[2],
                tx_sync_ff[1] & ~tx_sync_ff[2], ~tx_sync_ff[1] & tx_sync_ff[2]};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_rise = rise_ff;
      nxt_plus = plus_ff;
      nxt_ie = ie_ff;
      nxt_toen = toen_ff;
      nxt_monen = monen_ff;
      nxt_flag = flag_ff;
      nxt_rdata = 32'h0000_0000;
      if (lo_en) begin
         case (ADDR_IN)
            OFS_CLOCK_CONFIG: begin
               nxt_cfg = {WDATA_IN[POS_FAST], WDATA_IN[POS_DUTY], WDATA_IN[11:0]};
            end
            OFS_RISE_TIME: begin
               nxt_rise = WDATA_IN[5:0];
            end
            OFS_FRAME_MON: begin
               nxt_ie = WDATA_IN[POS_IE_LO+3:POS_IE_LO];
               nxt_toen = WDATA_IN[POS_TOEN];
               nxt_monen = WDATA_IN[POS_MONEN];
               nxt_flag = flag_ff & WDATA_IN[POS_RFR:POS_TFF];
            end
            OFS_PLUS_SPEED: begin
               nxt_plus = WDATA_IN[0];
            end
            default: begin
            end
         endcase
      end
      // Set wins over a clear in the same cycle.
      if (monen_ff) begin
         nxt_flag = nxt_flag | ev;
      end
      if (RD_IN) begin
         case (ADDR_IN)
            OFS_CLOCK_CONFIG: nxt_rdata = {16'h0000, cfg_ff.fast, cfg_ff.duty, 2'b00,
                                           cfg_ff.count};
            OFS_RISE_TIME: nxt_rdata = {26'h000_0000, rise_ff};
            OFS_FRAME_MON: nxt_rdata = {16'h0000, flag_ff, 2'b00, rx_sync_ff[1],
                                        tx_sync_ff[1], ie_ff, 2'b00, toen_ff,
                                        monen_ff};
            OFS_PLUS_SPEED: nxt_rdata = {31'h0000_0000, plus_ff};
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
      nxt_irq = |(nxt_flag & nxt_ie);
   end

   // Timeout: the frame clock must show an edge within the limit while a frame is active.
   always_comb begin
      nxt_tmo = tmo_ff;
      nxt_tmo_out = tmo_out_ff;
      if (!monen_ff || !toen_ff) begin
         nxt_tmo = '0;
         nxt_tmo_out = 1'b0;
      end else if (fc_sync_ff[1] != fc_sync_ff[2] || !(rx_sync_ff[1] | tx_sync_ff[1])) begin
         nxt_tmo = '0;
      end else if (tmo_ff == TMO_W'(FRAME_TIMEOUT_CYCLES - 1)) begin
         nxt_tmo_out = 1'b1;
      end else begin
         nxt_tmo = tmo_ff + TMO_W'(1);
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (RST_IN) begin
         cfg_ff <= '0;
         rise_ff <= RST_RISE_TIME;
         plus_ff <= 1'b0;
         flag_ff <= 4'h0;
         ie_ff <= 4'h0;
         toen_ff <= 1'b0;
         monen_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         irq_ff <= 1'b0;
         tmo_ff <= '0;
         tmo_out_ff <= 1'b0;
      end else begin
         cfg_ff <= nxt_cfg;
         rise_ff <= nxt_rise;
         plus_ff <= nxt_plus;
         flag_ff <= nxt_flag;
         ie_ff <= nxt_ie;
         toen_ff <= nxt_toen;
         monen_ff <= nxt_monen;
         rdata_ff <= nxt_rdata;
         irq_ff <= nxt_irq;
         tmo_ff <= nxt_tmo;
         tmo_out_ff <= nxt_tmo_out;
      end
   end

   scl_gen u_scl_gen (
      .clk_in(SYS_CLK_IN),
      .rst_in(RST_IN),
      .run_in(MASTER_RUN_IN),
      .cfg_in(cfg_ff),
      .scl_out(scl_w)
   );

   logic unused_hi;
   assign unused_hi = hi_en;
   assign RDATA_OUT = rdata_ff;
   assign SCL_OUT = scl_w;
   assign MAX_RISE_OUT = rise_ff;
   assign PLUS_SPEED_OUT = plus_ff;
   assign FRAME_TIMEOUT_OUT = tmo_out_ff;
   assign IRQ_OUT = irq_ff;
endmodule
